// ### hdl/stpf_top.sv
// Serial transmit path with holding register, hidden shifter and format register.
// Assumes halfBitTick comes from a bit-rate divider on the same clock, and that
// standby is a same-domain level from power control.
//
// Functional notes
// - Shifter sends bit 0 first
// - Empty shifter loads holding byte, starts sending
// - Auto reload after byte unless holding empty
// - Shifter has no register address
// - Holding register always readable and writable
// - Holding register all ones on reset, standby
// - Format register read/write, zero on reset/standby
// - Bit 7: async or synchronous mode
// - Card mode bit 7: finish at 12.5/11.0
// - Bit 6: 8 or 7 bit async
// - Seven-bit mode drops holding bit 7
// - Bit 5: parity in async only
// - Bit 4: even or odd parity
// - Bit 3: one or two stop bits
// - Bit 2: multiprocessor format overrides parity, not in card mode
// - Bits 1:0 pick prescaler 1/4/16/64
// - Transmit disabled holds holding-empty at one
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
module stpf_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic standby,
  input wire logic halfBitTick,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  output logic serialOut,
  output logic prescaleTick,
  output logic txBusy
);
  import stpf_pkg::*;

  // Transmit sequencer states
  typedef enum logic [2:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_EXTRA,
    TX_STOP,
    TX_GUARD
  } stpf_tx_state_type;

  stpf_fmt_type format_reg; // Frame format register
  logic [7:0] ctrl_reg; // Control, transmit enable
  logic [7:0] hold_reg; // Transmit holding byte
  logic [7:0] card_reg; // Card mode register
  logic emptyFlag_reg; // Holding empty flag
  logic finishedFlag_reg; // Transmit finished flag
  logic mpBit_reg; // Multiprocessor bit to send
  logic [7:0] shifter_reg; // Hidden shifter, no address
  stpf_tx_state_type state_reg; // Sequencer state
  stpf_tx_state_type state_next;
  logic [2:0] bitCnt_reg; // Data bit index
  logic half_reg; // Second half of bit time
  logic stopCnt_reg; // Second stop bit pending
  logic [4:0] halfCnt_reg; // Half bits since start, card mode
  logic extraBit_reg; // Parity or multiprocessor bit value
  logic [5:0] preCnt_reg; // Prescaler counter
  logic serialOut_reg;
  logic [7:0] rdData_reg;

  // Decoded controls
  logic cardMode;
  logic syncMode;
  logic txEnable;
  logic bitEnd;
  logic frameEnd;
  logic loadShifter;
  logic sevenBit;
  logic [2:0] lastBit;
  logic useExtra;
  logic [7:0] loadData;
  logic clearEmpty;
  logic clearFinished;
  logic wrFormat;
  logic wrHold;
  logic wrFlag;

  assign cardMode = card_reg[STPF_BIT_CARDIF];
  assign syncMode = format_reg.modeOrGuard & ~cardMode;
  assign txEnable = ctrl_reg[STPF_BIT_TXEN];
  assign sevenBit = format_reg.charLengthSel & ~syncMode & ~cardMode;
  assign lastBit = sevenBit ? STPF_LAST_BIT_7 : STPF_LAST_BIT_8;
  // Parity or multiprocessor bit only in async; card always has parity
  assign useExtra = cardMode | (~syncMode &
                    (format_reg.parityEnable | format_reg.multiprocFormat));
  // Seven-bit characters leave out bit 7
  assign loadData = sevenBit ? {1'b0, hold_reg[6:0]} : hold_reg;
  assign bitEnd = halfBitTick & half_reg;
  assign wrFormat = regWr & (regAddr == STPF_OFS_FORMAT);
  assign wrHold = regWr & (regAddr == STPF_OFS_HOLD);
  assign wrFlag = regWr & (regAddr == STPF_OFS_FLAG);
  // Writing zero clears a flag, writing one leaves it
  assign clearEmpty = wrFlag & ~regWrData[STPF_BIT_EMPTY];
  assign clearFinished = wrFlag & ~regWrData[STPF_BIT_FINISHED];
  assign txBusy = (state_reg != TX_IDLE);

  // Frame end detection per mode
  always_comb begin
    frameEnd = 1'b0;
    unique case (state_reg)
      TX_DATA: frameEnd = bitEnd & syncMode & (bitCnt_reg == lastBit);
      TX_STOP: frameEnd = bitEnd & ~stopCnt_reg;
      TX_GUARD: frameEnd = halfBitTick &
                (halfCnt_reg == (format_reg.modeOrGuard ? STPF_HALVES_SHORT - 5'h01
                                                        : STPF_HALVES_LONG - 5'h01));
      default: frameEnd = 1'b0;
    endcase
  end

  // Shifter loads when idle or at frame end and holding has data
  assign loadShifter = txEnable & ~emptyFlag_reg &
                       ((state_reg == TX_IDLE) | frameEnd);

  // Next state of the sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      TX_IDLE: begin
        if (loadShifter) begin
          state_next = syncMode ? TX_DATA : TX_START;
        end
      end
      TX_START: begin
        if (bitEnd) begin
          state_next = TX_DATA;
        end
      end
      TX_DATA: begin
        if (bitEnd && (bitCnt_reg == lastBit)) begin
          if (syncMode) begin
            // Sync frames carry no parity and no stop bit
            state_next = loadShifter ? TX_DATA : TX_IDLE;
          end else begin
            state_next = useExtra ? TX_EXTRA : TX_STOP;
          end
        end
      end
      TX_EXTRA: begin
        if (bitEnd) begin
          state_next = cardMode ? TX_GUARD : TX_STOP;
        end
      end
      TX_STOP: begin
        if (frameEnd) begin
          state_next = loadShifter ? TX_START : TX_IDLE;
        end
      end
      TX_GUARD: begin
        if (frameEnd) begin
          state_next = loadShifter ? TX_START : TX_IDLE;
        end
      end
      default: state_next = TX_IDLE;
    endcase
  end

  // Sequencer state register
  always_ff @(posedge clk) begin
    if (rst || standby) begin
      state_reg <= TX_IDLE;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  // Half-bit phase and bit counters
  always_ff @(posedge clk) begin
    if (rst || standby) begin
      half_reg <= 1'b0;
      bitCnt_reg <= 3'h0;
      stopCnt_reg <= 1'b0;
    end else if (clkEn) begin
      if (loadShifter) begin
        // New frame starts on a bit boundary
        half_reg <= 1'b0;
        bitCnt_reg <= 3'h0;
        stopCnt_reg <= 1'b0;
      end else if (halfBitTick) begin
        half_reg <= ~half_reg;
        if (half_reg && state_reg == TX_DATA) begin
          bitCnt_reg <= bitCnt_reg + 3'h1;
        end
        // Two stop bits: last bit before stop arms the second, first stop end clears it
        if (half_reg && state_reg != TX_STOP) begin
          stopCnt_reg <= format_reg.stopTwo;
        end else if (half_reg) begin
          stopCnt_reg <= 1'b0;
        end
      end
    end
  end

  // Half-bit counter from start bit, card mode finish timing
  always_ff @(posedge clk) begin
    if (rst || standby) begin
      halfCnt_reg <= 5'h00;
    end else if (clkEn) begin
      if (loadShifter) begin
        halfCnt_reg <= 5'h00;
      end else if (halfBitTick && state_reg != TX_IDLE) begin
        halfCnt_reg <= halfCnt_reg + 5'h01;
      end
    end
  end

  // Hidden shifter, moves right so bit 0 leaves first
  always_ff @(posedge clk) begin
    if (rst || standby) begin
      shifter_reg <= 8'h00;
      extraBit_reg <= 1'b0;
    end else if (clkEn) begin
      if (loadShifter) begin
        shifter_reg <= loadData;
        if (format_reg.multiprocFormat && !cardMode) begin
          // Multiprocessor bit replaces parity
          extraBit_reg <= mpBit_reg;
        end else begin
          // Parity makes ones count even, or odd when selected
          extraBit_reg <= (^loadData) ^ format_reg.paritySelOdd;
        end
      end else if (bitEnd && state_reg == TX_DATA) begin
        shifter_reg <= {1'b0, shifter_reg[7:1]};
      end
    end
  end

  // Serial output line, idles high
  always_ff @(posedge clk) begin
    if (rst || standby) begin
      serialOut_reg <= 1'b1;
    end else if (clkEn) begin
      unique case (state_next)
        TX_START: serialOut_reg <= 1'b0;
        TX_DATA: serialOut_reg <= loadShifter ? loadData[0] : ((state_reg == TX_DATA && bitEnd) ?
                                  shifter_reg[1] : shifter_reg[0]);
        TX_EXTRA: serialOut_reg <= extraBit_reg;
        default: serialOut_reg <= 1'b1;
      endcase
    end
  end

  assign serialOut = serialOut_reg;

  // Holding-empty flag: set on load or when disabled, set wins
  always_ff @(posedge clk) begin
    if (rst || standby) begin
      emptyFlag_reg <= STPF_RST_FLAG[STPF_BIT_EMPTY];
    end else if (clkEn) begin
      if (!txEnable) begin
        emptyFlag_reg <= 1'b1;
      end else if (loadShifter) begin
        emptyFlag_reg <= 1'b1;
      end else if (clearEmpty) begin
        emptyFlag_reg <= 1'b0;
      end
    end
  end

  // Finished flag: set at frame end with nothing to reload
  always_ff @(posedge clk) begin
    if (rst || standby) begin
      finishedFlag_reg <= STPF_RST_FLAG[STPF_BIT_FINISHED];
    end else if (clkEn) begin
      if (frameEnd && !loadShifter) begin
        finishedFlag_reg <= 1'b1;
      end else if (state_reg == TX_DATA && bitEnd && syncMode &&
                   bitCnt_reg == lastBit && !loadShifter) begin
        finishedFlag_reg <= 1'b1;
      end else if (loadShifter || clearFinished) begin
        finishedFlag_reg <= 1'b0;
      end
    end
  end

  // Multiprocessor bit value, software owned
  always_ff @(posedge clk) begin
    if (rst || standby) begin
      mpBit_reg <= STPF_RST_FLAG[STPF_BIT_MPBIT];
    end else if (clkEn && wrFlag) begin
      mpBit_reg <= regWrData[STPF_BIT_MPBIT];
    end
  end

  // Holding register, writable at any time
  always_ff @(posedge clk) begin
    if (rst || standby) begin
      hold_reg <= STPF_RST_HOLD;
    end else if (clkEn && wrHold) begin
      hold_reg <= regWrData;
    end
  end

  // Format register
  always_ff @(posedge clk) begin
    if (rst || standby) begin
      format_reg <= stpf_fmt_type'(STPF_RST_FORMAT);
    end else if (clkEn && wrFormat) begin
      format_reg <= stpf_fmt_type'(regWrData);
    end
  end

  // Control and card mode registers
  always_ff @(posedge clk) begin
    if (rst || standby) begin
      ctrl_reg <= STPF_RST_CTRL;
      card_reg <= STPF_RST_CARD;
    end else if (clkEn && regWr) begin
      if (regAddr == STPF_OFS_CTRL) begin
        ctrl_reg <= regWrData;
      end
      if (regAddr == STPF_OFS_CARD) begin
        card_reg <= regWrData;
      end
    end
  end

  // Prescaler counter, free running
  always_ff @(posedge clk) begin
    if (rst || standby) begin
      preCnt_reg <= 6'h00;
      prescaleTick <= 1'b0;
    end else if (clkEn) begin
      preCnt_reg <= preCnt_reg + 6'h01;
      unique case ({format_reg.clkPrescaleHi, format_reg.clkPrescaleLo})
        2'b00: prescaleTick <= 1'b1;
        2'b01: prescaleTick <= (preCnt_reg & STPF_PRE_DIV4) == STPF_PRE_DIV4;
        2'b10: prescaleTick <= (preCnt_reg & STPF_PRE_DIV16) == STPF_PRE_DIV16;
        2'b11: prescaleTick <= preCnt_reg == STPF_PRE_DIV64;
      endcase
    end
  end

  // Read data, one cycle after strobe; shifter never readable
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_reg <= 8'h00;
    end else if (clkEn && regRd) begin
      unique case (regAddr)
        STPF_OFS_FORMAT: rdData_reg <= format_reg;
        STPF_OFS_CTRL: rdData_reg <= ctrl_reg;
        STPF_OFS_HOLD: rdData_reg <= hold_reg;
        STPF_OFS_FLAG: rdData_reg <= {emptyFlag_reg | ~txEnable, 4'h0, finishedFlag_reg,
                                      1'b0, mpBit_reg};
        STPF_OFS_CARD: rdData_reg <= card_reg;
        default: rdData_reg <= 8'h00;
      endcase
    end else if (clkEn) begin
      rdData_reg <= 8'h00;
    end
  end

  assign regRdData = rdData_reg;

endmodule

// ### shared/stpf_pkg.sv
// Package for the serial transmit path and frame format block.
// Assumes a byte-wide register port and a single 250 MHz clock domain.
package stpf_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] STPF_OFS_FORMAT = 4'h0;
  localparam logic [3:0] STPF_OFS_CTRL = 4'h2;
  localparam logic [3:0] STPF_OFS_HOLD = 4'h3;
  localparam logic [3:0] STPF_OFS_FLAG = 4'h4;
  localparam logic [3:0] STPF_OFS_CARD = 4'h6;

  // Values after reset and after standby entry
  localparam logic [7:0] STPF_RST_FORMAT = 8'h00;
  localparam logic [7:0] STPF_RST_CTRL = 8'h00;
  localparam logic [7:0] STPF_RST_HOLD = 8'hFF;
  localparam logic [7:0] STPF_RST_FLAG = 8'h84;
  localparam logic [7:0] STPF_RST_CARD = 8'hF2;

  // Field positions
  localparam int STPF_BIT_TXEN = 5;
  localparam int STPF_BIT_EMPTY = 7;
  localparam int STPF_BIT_FINISHED = 2;
  localparam int STPF_BIT_MPBIT = 0;
  localparam int STPF_BIT_CARDIF = 0;

  // Index of the last data bit of a character
  localparam logic [2:0] STPF_LAST_BIT_8 = 3'h7;
  localparam logic [2:0] STPF_LAST_BIT_7 = 3'h6;

  // Finished-flag points in half bit times after start bit begins
  localparam logic [4:0] STPF_HALVES_LONG = 5'h19;
  localparam logic [4:0] STPF_HALVES_SHORT = 5'h16;

  // Prescaler masks for divide by 4, 16, 64
  localparam logic [5:0] STPF_PRE_DIV4 = 6'h03;
  localparam logic [5:0] STPF_PRE_DIV16 = 6'h0F;
  localparam logic [5:0] STPF_PRE_DIV64 = 6'h3F;

  // Format register layout, bit 7 down to bit 0
  typedef struct packed {
    logic modeOrGuard;   // Sync mode, or guard_time_select in card mode
    logic charLengthSel; // 1: seven-bit characters
    logic parityEnable;  // Parity bit added
    logic paritySelOdd;  // 1: odd parity
    logic stopTwo;       // 1: two stop bits
    logic multiprocFormat; // Multiprocessor format
    logic clkPrescaleHi;
    logic clkPrescaleLo;
  } stpf_fmt_type;

endpackage

// ### tb/stpf_line_model.sv
// Line model: bit-rate tick source and a far-end frame sampler.
// Assumes one bit spans two ticks and the line idles high.
`timescale 1ns/1ps
module stpf_line_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic line,
  input wire logic [3:0] rxLen,
  output logic halfBitTick,
  output logic [11:0] frameBits,
  output logic [7:0] frameCount
);
  logic [2:0] divCnt; // Eight clocks per half bit
  logic [3:0] phase; // Clocks to next sample
  logic [3:0] bitIdx; // Next bit slot
  logic active; // Inside a frame
  logic lineDly; // Line one clock ago
  assign halfBitTick = (divCnt == 3'h7);
  // Free-running divider
  always_ff @(posedge clk) begin
    divCnt <= rst ? 3'h0 : divCnt + 3'h1;
  end
  // Sample mid-bit after a falling edge, first bit in slot 0
  always_ff @(posedge clk) begin
    lineDly <= rst ? 1'b1 : line;
    if (rst) begin
      active <= 1'b0;
      frameCount <= 8'h00;
    end else if (!active) begin
      if (lineDly && !line) begin
        active <= 1'b1;
        phase <= 4'h7;
        bitIdx <= 4'h0;
        frameBits <= 12'h000;
      end
    end else if (phase != 4'h0) begin
      phase <= phase - 4'h1;
    end else begin
      frameBits[bitIdx] <= line;
      phase <= 4'hF;
      bitIdx <= bitIdx + 4'h1;
      if (bitIdx == rxLen - 4'h1) begin
        active <= 1'b0;
        frameCount <= frameCount + 8'h01;
      end
    end
  end
endmodule

// ### tb/stpf_top_asserts.sv
// Checker for the serial transmit block, bound to its top module.
// Assumes register shadows can be rebuilt from port writes alone.
`timescale 1ns/1ps
module stpf_top_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic standby,
  input wire logic halfBitTick,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic serialOut,
  input wire logic prescaleTick,
  input wire logic txBusy
);
  import stpf_pkg::*;
  logic [7:0] fmtShadow; // Format as written
  logic [7:0] holdShadow; // Holding byte as written
  logic teShadow; // Transmit enable as written
  logic rdNow; // Read taken this cycle
  assign rdNow = clkEn && regRd;
  // Mirror writes; reset and standby restore defaults
  always_ff @(posedge clk) begin
    if (clkEn && (rst || standby)) begin
      fmtShadow <= 8'h00;
      holdShadow <= 8'hFF;
      teShadow <= 1'b0;
    end else if (clkEn && regWr) begin
      if (regAddr == STPF_OFS_FORMAT) fmtShadow <= regWrData;
      if (regAddr == STPF_OFS_HOLD) holdShadow <= regWrData;
      if (regAddr == STPF_OFS_CTRL) teShadow <= regWrData[STPF_BIT_TXEN];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_IDLE: assert property (!txBusy |-> serialOut)
    else $error("line not idle high");
  AST_START: assert property ($rose(txBusy) && !fmtShadow[7] |-> ##[0:1] !serialOut)
    else $error("no start bit");
  AST_SHIFT: assert property (txBusy && $past(txBusy) && $changed(serialOut) |-> $past(halfBitTick))
    else $error("bit changed off tick");
  AST_NOLOAD: assert property (!teShadow && !txBusy |=> !txBusy)
    else $error("sent while disabled");
  AST_TEDIS: assert property (!teShadow && rdNow && regAddr == STPF_OFS_FLAG |=> regRdData[7])
    else $error("empty flag low while disabled");
  AST_RDZERO: assert property (clkEn && !regRd |=> regRdData == 8'h00)
    else $error("read data not cleared");
  AST_UNMAP: assert property (rdNow && (regAddr == 4'h1 || regAddr == 4'h5) |=> regRdData == 8'h00)
    else $error("hidden place readable");
  AST_FMT_RD: assert property (rdNow && regAddr == STPF_OFS_FORMAT |=> regRdData == $past(fmtShadow))
    else $error("format readback wrong");
  AST_HOLD_RD: assert property (rdNow && regAddr == STPF_OFS_HOLD |=> regRdData == $past(holdShadow))
    else $error("holding readback wrong");
  AST_PRE1: assert property (clkEn && !rst && !standby && fmtShadow[1:0] == 2'b00 |=> prescaleTick)
    else $error("undivided tick missing");
endmodule
bind stpf_top stpf_top_asserts u_asserts (.clk(clk), .rst(rst), .clkEn(clkEn),
  .standby(standby), .halfBitTick(halfBitTick), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .serialOut(serialOut),
  .prescaleTick(prescaleTick), .txBusy(txBusy));

// ### tb/tb.sv
// Testbench: register tasks and frame checks against a line model.
// Assumes the design alone on one 250 MHz clock.
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; $display("BAD %0t %h vs %h", $time, a, e); end end
module tb;
  import stpf_pkg::*;
  logic clk = 1'b0; // 4 ns period
  logic rst = 1'b1;
  logic standby = 1'b0;
  logic halfBitTick;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic serialOut;
  logic prescaleTick;
  logic txBusy;
  logic [3:0] rxLen = 4'hA; // Bits the model samples per frame
  logic [11:0] frameBits;
  logic [7:0] frameCount;
  int miscompares = 0;
  int compares = 0;
  always #2 clk = ~clk;
  stpf_top DUT (.clk(clk), .rst(rst), .clkEn(1'b1), .standby(standby),
    .halfBitTick(halfBitTick), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .serialOut(serialOut),
    .prescaleTick(prescaleTick), .txBusy(txBusy));
  stpf_line_model partner (.clk(clk), .rst(rst), .line(serialOut), .rxLen(rxLen),
    .halfBitTick(halfBitTick), .frameBits(frameBits), .frameCount(frameCount));
  // Counts, verdict, end of run
  task automatic test_done();
    $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // One-cycle read, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask
  // Expected line bits, slot 0 first, and their count
  task automatic calc(input logic [7:0] f, input logic [7:0] d, input logic m,
    output logic [11:0] e, output logic [3:0] n);
    e = 12'h000;
    if (f[7]) begin
      e[8:0] = {1'b1, d}; // Data only, then idle
      n = 4'h9;
    end else begin
      n = 4'h1; // Slot 0 is the zero start bit
      for (int i = 0; i < (f[6] ? 7 : 8); i++) begin
        e[n] = d[i];
        n++;
      end
      if (f[2] || f[5]) begin
        e[n] = f[2] ? m : ^(d & (f[6] ? 8'h7F : 8'hFF)) ^ f[4];
        n++;
      end
      e[n] = 1'b1;
      e[n + 4'h1] = f[3];
      n = n + (f[3] ? 4'h2 : 4'h1);
    end
  endtask
  // Bounded wait for the next captured frame
  task automatic waitFrame(input logic [11:0] e);
    logic [7:0] c0;
    c0 = frameCount;
    for (int i = 0; i < 1000 && frameCount === c0; i++) @(posedge clk);
    if (frameCount === c0) begin
      miscompares++;
      test_done();
    end else begin
      `CHK(frameBits, e)
    end
  endtask
  task automatic send(input logic [7:0] f, input logic [7:0] d, input logic m);
    logic [11:0] e;
    logic [3:0] n;
    calc(f, d, m, e, n);
    rxLen = n;
    wr(STPF_OFS_CTRL, 8'h00);
    wr(STPF_OFS_FORMAT, f);
    wr(STPF_OFS_CTRL, 8'h20);
    wr(STPF_OFS_HOLD, d);
    wr(STPF_OFS_FLAG, {7'h00, m});
    waitFrame(e);
  endtask
  initial begin
    logic [7:0] d;
    logic [7:0] fmts [7];
    int t;
    fmts = '{8'h00, 8'h40, 8'h20, 8'h30, 8'h08, 8'h24, 8'h78};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdchk(STPF_OFS_FORMAT, 8'h00);
    rdchk(STPF_OFS_HOLD, 8'hFF);
    rdchk(STPF_OFS_FLAG, 8'h84);
    rdchk(4'h1, 8'h00);
    rdchk(4'h5, 8'h00);
    wr(STPF_OFS_HOLD, 8'h5A);
    wr(STPF_OFS_FLAG, 8'h00);
    rdchk(STPF_OFS_HOLD, 8'h5A);
    rd(STPF_OFS_FLAG, d);
    `CHK(d[7], 1'b1)
    repeat (64) @(posedge clk);
    `CHK(frameCount, 8'h00)
    $display("Test regs done");
    for (int i = 0; i < 7; i++) send(fmts[i], 8'h3A + 8'(i * 29), i[0]);
    repeat (200) @(posedge clk);
    `CHK(frameCount, 8'h07)
    `CHK(txBusy, 1'b0)
    $display("Test formats done");
    send(8'h00, 8'h5A, 1'b0);
    wr(STPF_OFS_HOLD, 8'hC3);
    wr(STPF_OFS_FLAG, 8'h00);
    waitFrame({2'h0, 1'b1, 8'hC3, 1'b0});
    $display("Test reload done");
    send(8'hE4, 8'hBC, 1'b0);
    $display("Test sync done");
    wr(STPF_OFS_CARD, 8'hF3);
    rdchk(STPF_OFS_CARD, 8'hF3);
    send(8'h20, 8'h96, 1'b0);
    rdchk(STPF_OFS_FLAG, 8'h80);
    repeat (64) @(posedge clk);
    rdchk(STPF_OFS_FLAG, 8'h84);
    wr(STPF_OFS_CARD, 8'hF2);
    $display("Test card done");
    for (int k = 0; k < 4; k++) begin
      wr(STPF_OFS_FORMAT, 8'(k));
      repeat (64) @(posedge clk);
      t = 0;
      for (int i = 0; i < 128; i++) begin
        @(posedge clk);
        #1;
        if (prescaleTick === 1'b1) t++;
      end
      `CHK(t, 128 >> (2 * k))
    end
    $display("Test prescale done");
    wr(STPF_OFS_FORMAT, 8'h3C);
    wr(STPF_OFS_HOLD, 8'h77);
    rdchk(STPF_OFS_FORMAT, 8'h3C);
    @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    rdchk(STPF_OFS_FORMAT, 8'h00);
    rdchk(STPF_OFS_HOLD, 8'hFF);
    $display("Test standby done");
    test_done();
  end
endmodule
